/* File: verilog/radio_sleep_params.svh */
// Constants, timing counts and behaviour summary of the radio sleep mode controller.
// Contract
// R1 - Sleep modes 1, 4 and 5 give asynchronous low power, set per device.
// R2 - Modes 7 and 8: a non-coordinator never joins coordinator nomination or election.
// R3 - Traffic for an asynchronous sleeper is never buffered; packets arriving asleep are lost.
// R4 - Pin sleep needs sleep mode 1 and sleep pin function 1, set by software.
// R5 - Asserted sleep request: finish ongoing transfer, go idle, then sleep.
// R6 - In pin sleep, all serial input and radio activity are ignored.
// R7 - Deasserted request wakes device; clear-to-send low once ready; host waits for it.
// R8 - Pin function 0 with SPI sleep control 1: SPI select acts as sleep request.
// R9 - Software must not set the other three SPI pin functions to peripheral.
// R10 - Mode 4 wakes once per cycle period and sends a poll to the coordinator.
// R11 - The coordinator answers a poll with data queued for that remote.
// R12 - No data: sleep another cycle; data: stay awake until wake time expires.
// R13 - Sleep options bit 8 keeps every wake for the full wake time.
// R14 - Coordinator routing role 1, sleeper 4, sleeper destination is coordinator address.
// R15 - Senders mark sleeper traffic point-to-point so the coordinator queues it.
// R16 - When enabled, clear-to-send goes low at each cyclic wake.
// R17 - Awake indicator rises only after the configured count of sleep periods; the code also raises it on a wake that brings data.
// R18 - Asynchronous sleepers should not route; configure them as end devices.
// R19 - Flow control 1: clear-to-send high asleep, low awake and accepting.
// R20 - Awake indicator low while asleep, high while awake and accepting.
// R21 - The sleep-period count restarts whenever a cyclic wake delivers data.
`ifndef RADIO_SLEEP_PARAMS_SVH
`define RADIO_SLEEP_PARAMS_SVH

// Sleep mode select encodings.
`define SM_NONE          4'h0
`define SM_PIN           4'h1
`define SM_CYCLIC        4'h4
`define SM_CYCLIC_PIN    4'h5
`define SM_SYNC_SUPPORT  4'h7
`define SM_SYNC_CYCLIC   4'h8

// Sleep pin function encodings.
`define PINFN_DISABLED   3'h0
`define PINFN_SLEEP_REQ  3'h1

// Sleep option field positions.
`define SO_NON_COORD_BIT 1
`define SO_FULL_WAKE_BIT 8

// Timing: one timer tick per millisecond at 200 MHz.
`define CLK_MHZ          200
`define TICK_US          1000
`define TICK_CYCLES      (`TICK_US * `CLK_MHZ)
`define CYCLE_UNIT_MS    10
`define POLL_WINDOW_MS   30

`endif

/* File: verilog/radio_sleep_pkg.sv */
// Types shared by the radio sleep mode controller.
`default_nettype none
package radio_sleep_pkg;

	// Controller states, Gray coded along awake, drain, sleep, poll, hold.
	typedef enum logic [2:0] {
		ST_AWAKE = 3'h0,
		ST_DRAIN = 3'h1,
		ST_SLEEP = 3'h3,
		ST_POLL  = 3'h2,
		ST_HOLD  = 3'h6
	} state_t;

endpackage
`default_nettype wire

/* File: verilog/sleep_timer_if.sv */
// Load and expiry handshake between the controller and a millisecond timer.
`timescale 1ns/1ps
`default_nettype none
interface sleep_timer_if #(parameter int unsigned TW = 24);
	logic          load;
	logic [TW-1:0] value;
	logic          expired;

	modport ctrl  (output load, output value, input expired);
	modport timer (input load, input value, output expired);
endinterface
`default_nettype wire

/* File: verilog/sleep_ms_timer.sv */
// Down counter in millisecond ticks with a one-cycle expiry pulse.
`timescale 1ns/1ps
`default_nettype none
module sleep_ms_timer #(
	parameter int unsigned TW = 24
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        tick_i,
	sleep_timer_if.timer     tif
);

	logic [TW-1:0] cnt_r;
	logic          expired_r;

	// ---------------------------------------------------------------
	// Counter
	// ---------------------------------------------------------------
	// A load always wins over a tick so a restart is never lost.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
		end else if (tif.load) begin
			cnt_r <= tif.value;
		end else if (tick_i && cnt_r != '0) begin
			cnt_r <= cnt_r - TW'(1);
		end
	end

	// Expiry fires on the tick that takes the count from one to zero.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			expired_r <= 1'b0;
		end else begin
			expired_r <= !tif.load && tick_i && cnt_r == TW'(1);
		end
	end

	assign tif.expired = expired_r;

endmodule
`default_nettype wire

/* File: verilog/radio_sleep_mode_controller.sv */
// Sleep mode controller: pin sleep, cyclic polling sleep and the host-side pins.
`timescale 1ns/1ps
`default_nettype none
`include "radio_sleep_params.svh"
module radio_sleep_mode_controller #(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
	parameter int unsigned TW          = 24
) (
	input  wire logic                    CLK_I,
	input  wire logic                    RST_N_I,
	input  wire logic [3:0]              SLEEP_MODE_SELECT_I,
	input  wire logic [2:0]              SLEEP_PIN_FUNCTION_CONFIG_I,
	input  wire logic                    SPI_SLEEP_CTRL_ENABLE_I,
	input  wire logic                    FLOW_CTRL_PIN_CONFIG_I,
	input  wire logic                    AWAKE_IND_ENABLE_I,
	input  wire logic [15:0]             SLEEP_OPTIONS_I,
	input  wire logic [15:0]             CYCLE_PERIOD_I,
	input  wire logic [15:0]             WAKE_TIME_I,
	input  wire logic [15:0]             SLEEP_PERIOD_COUNT_I,
	input  wire logic                    HOST_SLEEP_REQUEST_PIN_I,
	input  wire logic                    SPI_SELECT_I,
	input  wire logic                    RADIO_BUSY_I,
	input  wire logic                    RADIO_RX_VALID_I,
	input  wire logic                    SERIAL_RX_VALID_I,
	input  wire logic                    POLL_DATA_VALID_I,
	output logic                         CTS_N_O,
	output logic                         AWAKE_O,
	output logic                         POLL_REQ_O,
	output logic                         RADIO_RX_ACCEPT_O,
	output logic                         SERIAL_RX_ACCEPT_O,
	output logic                         RX_LOST_O,
	output logic                         ELECTION_ENABLE_O,
	output radio_sleep_pkg::state_t      STATE_O
);
	import radio_sleep_pkg::*;

	localparam int unsigned PW = $clog2(TICK_CYCLES + 1);

	// ---------------------------------------------------------------
	// Configuration decode
	// ---------------------------------------------------------------
	logic pin_mode;
	logic cyc_mode;
	logic cyc_pin_mode;
	logic sync_mode;
	logic src_en;
	logic sleep_req;
	logic full_wake;
	logic activity;

	// Each device picks its own mode; only 1, 4 and 5 ever sleep here.
	assign pin_mode     = SLEEP_MODE_SELECT_I == `SM_PIN; // R1
	assign cyc_pin_mode = SLEEP_MODE_SELECT_I == `SM_CYCLIC_PIN;
	assign cyc_mode     = SLEEP_MODE_SELECT_I == `SM_CYCLIC || cyc_pin_mode; // R1
	assign sync_mode    = SLEEP_MODE_SELECT_I == `SM_SYNC_SUPPORT
	                   || SLEEP_MODE_SELECT_I == `SM_SYNC_CYCLIC;

	// The SPI select pin stands in for the sleep request pin when the
	// request pin function is disabled and SPI sleep control is on.
	always_comb begin
		if (SLEEP_PIN_FUNCTION_CONFIG_I == `PINFN_SLEEP_REQ) begin
			src_en    = 1'b1;
			sleep_req = HOST_SLEEP_REQUEST_PIN_I;
		end else if (SLEEP_PIN_FUNCTION_CONFIG_I == `PINFN_DISABLED
		             && SPI_SLEEP_CTRL_ENABLE_I) begin
			src_en    = 1'b1; // R8
			sleep_req = SPI_SELECT_I; // R8
		end else begin
			src_en    = 1'b0;
			sleep_req = 1'b0;
		end
	end

	assign full_wake = SLEEP_OPTIONS_I[`SO_FULL_WAKE_BIT];
	assign activity  = RADIO_RX_VALID_I || SERIAL_RX_VALID_I;

	// ---------------------------------------------------------------
	// Millisecond tick
	// ---------------------------------------------------------------
	logic [PW-1:0] pre_r;
	logic          tick_r;

	// A free prescaler keeps both timers on a common time base.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			pre_r  <= '0;
			tick_r <= 1'b0;
		end else if (pre_r == PW'(TICK_CYCLES - 1)) begin
			pre_r  <= '0;
			tick_r <= 1'b1;
		end else begin
			pre_r  <= pre_r + PW'(1);
			tick_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Timers
	// ---------------------------------------------------------------
	sleep_timer_if #(.TW(TW)) cyc_tif ();
	sleep_timer_if #(.TW(TW)) wake_tif ();

	sleep_ms_timer #(.TW(TW)) u_cycle_timer (
		.clk_i   (CLK_I),
		.rst_n_i (RST_N_I),
		.tick_i  (tick_r),
		.tif     (cyc_tif.timer)
	);

	sleep_ms_timer #(.TW(TW)) u_wake_timer (
		.clk_i   (CLK_I),
		.rst_n_i (RST_N_I),
		.tick_i  (tick_r),
		.tif     (wake_tif.timer)
	);

	logic [TW-1:0] cycle_ms;
	logic [TW-1:0] wake_ms;
	logic [TW-1:0] poll_ms;

	// A zero setting is raised to one tick, since a zero load never expires.
	assign cycle_ms = (CYCLE_PERIOD_I == 16'h0000) ? TW'(1)
	                : TW'(CYCLE_PERIOD_I) * TW'(`CYCLE_UNIT_MS);
	assign wake_ms  = (WAKE_TIME_I == 16'h0000) ? TW'(1) : TW'(WAKE_TIME_I);
	assign poll_ms  = TW'(`POLL_WINDOW_MS);

	// ---------------------------------------------------------------
	// State machine
	// ---------------------------------------------------------------
	state_t        state_r;
	state_t        state_nxt;
	logic          cyc_load;
	logic          wake_load;
	logic [TW-1:0] wake_val;
	logic          poll_nxt;
	logic          wake_evt;
	logic          data_evt;

	always_comb begin
		state_nxt = state_r;
		cyc_load  = 1'b0;
		wake_load = 1'b0;
		wake_val  = wake_ms;
		poll_nxt  = 1'b0;
		wake_evt  = 1'b0;
		data_evt  = 1'b0;
		unique case (state_r)
			ST_AWAKE: begin
				// Pin sleep leaves only on request; cyclic modes head for sleep.
				if ((pin_mode && src_en && sleep_req) || cyc_mode) begin
					state_nxt = ST_DRAIN; // R5
				end
			end
			ST_DRAIN: begin
				// Any transfer in flight is finished before sleeping.
				if (pin_mode && !(src_en && sleep_req)) begin
					state_nxt = ST_AWAKE; // R7
				end else if (!pin_mode && !cyc_mode) begin
					state_nxt = ST_AWAKE;
				end else if (!RADIO_BUSY_I) begin
					state_nxt = ST_SLEEP; // R5
					cyc_load  = cyc_mode; // R10
				end
			end
			ST_SLEEP: begin
				if (pin_mode) begin
					if (!(src_en && sleep_req)) begin
						state_nxt = ST_AWAKE; // R7
					end
				end else if (!cyc_mode) begin
					state_nxt = ST_AWAKE;
				end else if (cyc_pin_mode && src_en && !sleep_req) begin
					// A low request level wakes for at least one wake time.
					state_nxt = ST_HOLD;
					wake_load = 1'b1;
					wake_evt  = 1'b1;
				end else if (cyc_tif.expired) begin
					poll_nxt  = 1'b1; // R10
					wake_load = 1'b1;
					wake_evt  = 1'b1;
					if (full_wake) begin
						state_nxt = ST_HOLD; // R13
					end else begin
						state_nxt = ST_POLL;
						wake_val  = poll_ms;
					end
				end
			end
			ST_POLL: begin
				if (POLL_DATA_VALID_I) begin
					state_nxt = ST_HOLD; // R12
					wake_load = 1'b1;
					data_evt  = 1'b1;
				end else if (wake_tif.expired || !cyc_mode) begin
					state_nxt = ST_DRAIN; // R12
				end
			end
			ST_HOLD: begin
				// Activity or a held request level pushes the sleep time out.
				if (activity || POLL_DATA_VALID_I
				    || (cyc_pin_mode && src_en && !sleep_req)) begin
					wake_load = 1'b1; // R12
					data_evt  = POLL_DATA_VALID_I || RADIO_RX_VALID_I;
				end else if (wake_tif.expired || !cyc_mode) begin
					state_nxt = ST_DRAIN; // R12
				end
			end
			default: begin
				state_nxt = ST_AWAKE;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			state_r <= ST_AWAKE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign cyc_tif.load   = cyc_load;
	assign cyc_tif.value  = cycle_ms;
	assign wake_tif.load  = wake_load;
	assign wake_tif.value = wake_val;

	// ---------------------------------------------------------------
	// Empty sleep period count
	// ---------------------------------------------------------------
	logic [15:0] empty_cnt_r;
	logic        ind_gate_r;
	logic        gate_now;

	// This wake is the counted one when it completes the configured run.
	assign gate_now = (17'(empty_cnt_r) + 17'h00001) >= 17'(SLEEP_PERIOD_COUNT_I);

	// Counts cyclic wakes in a row that brought no data; data restarts it.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			empty_cnt_r <= 16'h0000;
			ind_gate_r  <= 1'b0;
		end else if (data_evt) begin
			empty_cnt_r <= 16'h0000; // R21
			ind_gate_r  <= 1'b1;
		end else if (wake_evt) begin
			ind_gate_r <= gate_now; // R17
			if (gate_now) begin
				empty_cnt_r <= 16'h0000;
			end else if (empty_cnt_r != 16'hFFFF) begin
				empty_cnt_r <= empty_cnt_r + 16'h0001;
			end
		end else if (!cyc_mode) begin
			empty_cnt_r <= 16'h0000;
			ind_gate_r  <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	logic accept_nxt;
	logic ind_nxt;

	// Drain still finishes a transfer but takes no new serial data.
	assign accept_nxt = state_nxt == ST_AWAKE || state_nxt == ST_POLL
	                 || state_nxt == ST_HOLD;

	// In cyclic modes the indicator waits for the counted empty periods or for a wake that brings data.
	assign ind_nxt = accept_nxt
	              && (!cyc_mode || !AWAKE_IND_ENABLE_I || ind_gate_r
	                  || data_evt || (wake_evt && gate_now));

	// Gating the inputs here is what drops, rather than queues, traffic.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			RADIO_RX_ACCEPT_O  <= 1'b0;
			SERIAL_RX_ACCEPT_O <= 1'b0;
			RX_LOST_O          <= 1'b0;
		end else begin
			RADIO_RX_ACCEPT_O  <= accept_nxt; // R6
			SERIAL_RX_ACCEPT_O <= accept_nxt; // R6
			RX_LOST_O          <= RADIO_RX_VALID_I && !RADIO_RX_ACCEPT_O; // R3
		end
	end

	// Clear-to-send low means awake and ready; with flow control off it
	// is held low so a host that ignores it is never blocked.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			CTS_N_O <= 1'b1;
		end else if (FLOW_CTRL_PIN_CONFIG_I) begin
			CTS_N_O <= !accept_nxt; // R19 R16 R7
		end else begin
			CTS_N_O <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			AWAKE_O <= 1'b0;
		end else begin
			AWAKE_O <= ind_nxt; // R20 R17
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			POLL_REQ_O <= 1'b0;
		end else begin
			POLL_REQ_O <= poll_nxt; // R10
		end
	end

	// Nodes flagged as non-coordinators stay out of every election.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			ELECTION_ENABLE_O <= 1'b0;
		end else begin
			ELECTION_ENABLE_O <= sync_mode
			                  && !SLEEP_OPTIONS_I[`SO_NON_COORD_BIT]; // R2
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			STATE_O <= ST_AWAKE;
		end else begin
			STATE_O <= state_nxt;
		end
	end

endmodule
`default_nettype wire

/* File: verification/radio_sleep_asserts.sv */
// Port-level assertions for the radio sleep mode controller.
`timescale 1ns/1ps
`default_nettype none
module radio_sleep_checker (
	input wire logic	CLK_I,
	input wire logic	RST_N_I,
	input wire logic [3:0]	SLEEP_MODE_SELECT_I,
	input wire logic [2:0]	SLEEP_PIN_FUNCTION_CONFIG_I,
	input wire logic	FLOW_CTRL_PIN_CONFIG_I,
	input wire logic [15:0]	SLEEP_OPTIONS_I,
	input wire logic	HOST_SLEEP_REQUEST_PIN_I,
	input wire logic	RADIO_BUSY_I,
	input wire logic	RADIO_RX_VALID_I,
	input wire logic	POLL_DATA_VALID_I,
	input wire logic	CTS_N_O,
	input wire logic	AWAKE_O,
	input wire logic	POLL_REQ_O,
	input wire logic	RADIO_RX_ACCEPT_O,
	input wire logic	SERIAL_RX_ACCEPT_O,
	input wire logic	RX_LOST_O,
	input wire logic	ELECTION_ENABLE_O,
	input wire radio_sleep_pkg::state_t	STATE_O
);
	import radio_sleep_pkg::*;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Drain counts as asleep on the host pins, so both states share one flag.
	wire logic asleep = STATE_O inside {ST_DRAIN, ST_SLEEP};
	wire logic non_coord = SLEEP_OPTIONS_I[1];
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_sleep_cts_high: assert property (STATE_O == ST_SLEEP && $past(FLOW_CTRL_PIN_CONFIG_I) |-> CTS_N_O)
		else $error("clear-to-send low while asleep");
	a_asleep_ind_low: assert property (asleep |-> !AWAKE_O)
		else $error("awake indicator high while asleep");
	a_asleep_no_acc: assert property (asleep |-> !RADIO_RX_ACCEPT_O && !SERIAL_RX_ACCEPT_O)
		else $error("input accepted while asleep");
	a_lost_rx_flag: assert property (RADIO_RX_VALID_I && !RADIO_RX_ACCEPT_O |=> RX_LOST_O)
		else $error("refused packet not flagged lost");
	a_drain_busy_hold: assert property (STATE_O == ST_DRAIN && RADIO_BUSY_I |=> STATE_O != ST_SLEEP)
		else $error("slept during a transfer");
	a_pin_wake_ready: assert property (SLEEP_MODE_SELECT_I == 4'h1
		&& SLEEP_PIN_FUNCTION_CONFIG_I == 3'h1 && STATE_O == ST_SLEEP && !HOST_SLEEP_REQUEST_PIN_I
		|=> STATE_O == ST_AWAKE && !CTS_N_O)
		else $error("no wake on released request");
	a_poll_pulse_once: assert property (POLL_REQ_O |-> STATE_O inside {ST_POLL, ST_HOLD} && !CTS_N_O
		##1 !POLL_REQ_O)
		else $error("poll request malformed");
	a_poll_data_hold: assert property (STATE_O == ST_POLL && POLL_DATA_VALID_I |=> STATE_O == ST_HOLD)
		else $error("queued data did not hold awake");
	a_elect_role_gate: assert property (ELECTION_ENABLE_O |-> $past(SLEEP_MODE_SELECT_I) inside {4'h7, 4'h8}
		&& !$past(non_coord))
		else $error("election joined without role");
	c_pin_sleep: cover property (STATE_O == ST_SLEEP && SLEEP_MODE_SELECT_I == 4'h1);
	c_poll: cover property (POLL_REQ_O);
	c_hold: cover property (STATE_O == ST_HOLD);
endmodule
bind radio_sleep_mode_controller radio_sleep_checker u_chk (
	.CLK_I(CLK_I), .RST_N_I(RST_N_I), .SLEEP_MODE_SELECT_I(SLEEP_MODE_SELECT_I),
	.SLEEP_PIN_FUNCTION_CONFIG_I(SLEEP_PIN_FUNCTION_CONFIG_I),
	.FLOW_CTRL_PIN_CONFIG_I(FLOW_CTRL_PIN_CONFIG_I), .SLEEP_OPTIONS_I(SLEEP_OPTIONS_I),
	.HOST_SLEEP_REQUEST_PIN_I(HOST_SLEEP_REQUEST_PIN_I), .RADIO_BUSY_I(RADIO_BUSY_I),
	.RADIO_RX_VALID_I(RADIO_RX_VALID_I), .POLL_DATA_VALID_I(POLL_DATA_VALID_I),
	.CTS_N_O(CTS_N_O), .AWAKE_O(AWAKE_O), .POLL_REQ_O(POLL_REQ_O),
	.RADIO_RX_ACCEPT_O(RADIO_RX_ACCEPT_O), .SERIAL_RX_ACCEPT_O(SERIAL_RX_ACCEPT_O),
	.RX_LOST_O(RX_LOST_O), .ELECTION_ENABLE_O(ELECTION_ENABLE_O), .STATE_O(STATE_O)
);
`default_nettype wire

/* File: verification/coord_model.sv */
// Coordinator model that queues packets for a cyclic sleeper and answers its polls.
`timescale 1ns/1ps
`default_nettype none
module coord_model (
	input wire logic	clk_i,
	input wire logic	rst_n_i,
	input wire logic	poll_req_i,
	input wire logic	push_i,
	input wire logic [3:0]	dly_i,
	output logic	data_valid_o
);
	int	queued;
	logic [4:0]	wait_r;
	// An empty queue stays silent, so the sleeper must go back to sleep.
	// It stands for the one coordinator the sleeper targets and never routes.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			queued <= 0;
			wait_r <= 5'h00;
			data_valid_o <= 1'b0;
		end else begin
			data_valid_o <= (wait_r == 5'h01);
			// A push and a delivery in one cycle must both count.
			queued <= queued + (push_i ? 1 : 0) - ((wait_r == 5'h01) ? 1 : 0);
			if (poll_req_i && queued > 0) wait_r <= {1'b0, dly_i} + 5'h01;
			else if (wait_r != 5'h00) wait_r <= wait_r - 5'h01;
		end
	end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking testbench for the radio sleep mode controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import radio_sleep_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic host_req = 1'b0;
	logic spi_sel = 1'b0;
	logic spi_en = 1'b0;
	logic busy = 1'b0;
	logic rx_v = 1'b0;
	logic push = 1'b0;
	logic flow = 1'b1;
	logic awake_en = 1'b1;
	logic ser_v = 1'b0;
	logic [3:0] mode = 4'h0;
	logic [2:0] pinfn = 3'h1;
	logic [15:0] so = 16'h0000;
	logic cts_n, awake, poll, racc, sacc, lost, elect, dv, seen;
	state_t st;
	int checks = 0;
	int mismatches = 0;
	// 200 MHz clock.
	always #2.5 clk = ~clk;
	radio_sleep_mode_controller #(.TICK_CYCLES(4)) DUT (
		.CLK_I(clk), .RST_N_I(rst_n), .SLEEP_MODE_SELECT_I(mode),
		.SLEEP_PIN_FUNCTION_CONFIG_I(pinfn), .SPI_SLEEP_CTRL_ENABLE_I(spi_en),
		.FLOW_CTRL_PIN_CONFIG_I(flow), .AWAKE_IND_ENABLE_I(awake_en), .SLEEP_OPTIONS_I(so),
		.CYCLE_PERIOD_I(16'h0001), .WAKE_TIME_I(16'h0002), .SLEEP_PERIOD_COUNT_I(16'h0002),
		.HOST_SLEEP_REQUEST_PIN_I(host_req), .SPI_SELECT_I(spi_sel), .RADIO_BUSY_I(busy),
		.RADIO_RX_VALID_I(rx_v), .SERIAL_RX_VALID_I(ser_v), .POLL_DATA_VALID_I(dv),
		.CTS_N_O(cts_n), .AWAKE_O(awake), .POLL_REQ_O(poll), .RADIO_RX_ACCEPT_O(racc),
		.SERIAL_RX_ACCEPT_O(sacc), .RX_LOST_O(lost), .ELECTION_ENABLE_O(elect), .STATE_O(st)
	);
	coord_model u_coord (.clk_i(clk), .rst_n_i(rst_n), .poll_req_i(poll), .push_i(push),
		.dly_i(4'h3), .data_valid_o(dv));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task final_report();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	// Bounded wait for a state; running out ends the run at once.
	task wst(input state_t s, input int n);
		int i;
		i = 0;
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (st !== s && i < n);
		chk(st === s, "state wait ran out");
		if (st !== s) final_report();
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		cyc(3);
		chk(st === ST_AWAKE && cts_n === 1'b0 && awake === 1'b1, "idle pins");
		@(posedge clk);
		mode <= 4'h1;
		busy <= 1'b1;
		host_req <= 1'b1;
		wst(ST_DRAIN, 5);
		chk(cts_n === 1'b1 && awake === 1'b0, "drain pins");
		cyc(4);
		chk(st === ST_DRAIN, "slept during transfer");
		@(posedge clk);
		busy <= 1'b0;
		wst(ST_SLEEP, 5);
		@(posedge clk);
		rx_v <= 1'b1;
		@(posedge clk);
		rx_v <= 1'b0;
		#1 seen = lost;
		cyc(1);
		chk((seen | lost) === 1'b1 && racc === 1'b0 && sacc === 1'b0, "packet asleep");
		@(posedge clk);
		host_req <= 1'b0;
		wst(ST_AWAKE, 3);
		chk(cts_n === 1'b0 && awake === 1'b1 && racc === 1'b1, "wake pins");
		// The select line stands in for the host pin when the pin function is off.
		@(posedge clk);
		pinfn <= 3'h0;
		spi_en <= 1'b1;
		spi_sel <= 1'b1;
		wst(ST_SLEEP, 6);
		@(posedge clk);
		spi_sel <= 1'b0;
		wst(ST_AWAKE, 3);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			mode <= k[1] ? 4'h8 : 4'h7;
			so <= {14'h0000, k[0], 1'b0};
			cyc(2);
			chk(elect === ~k[0], "election gate");
		end
		// Cyclic sleep: two empty wakes, then one that carries queued data.
		@(posedge clk);
		mode <= 4'h4;
		so <= 16'h0000;
		wst(ST_SLEEP, 10);
		wst(ST_POLL, 100);
		chk(poll === 1'b1 && cts_n === 1'b0 && awake === 1'b0, "first wake");
		wst(ST_SLEEP, 200);
		wst(ST_POLL, 100);
		cyc(2);
		chk(awake === 1'b1, "count reached");
		@(posedge clk);
		push <= 1'b1;
		@(posedge clk);
		push <= 1'b0;
		wst(ST_SLEEP, 200);
		wst(ST_HOLD, 120);
		chk(awake === 1'b1 && racc === 1'b1, "data wake");
		cyc(4);
		chk(st === ST_HOLD, "wake time cut short");
		wst(ST_SLEEP, 40);
		wst(ST_POLL, 100);
		cyc(2);
		chk(awake === 1'b0, "count restarted");
		@(posedge clk);
		so <= 16'h0100;
		wst(ST_SLEEP, 200);
		wst(ST_HOLD, 100);
		chk(poll === 1'b1, "full wake poll");
		// Cyclic sleep with pin wake, flow control and indicator gating off.
		@(posedge clk);
		so <= 16'h0000;
		mode <= 4'h5;
		spi_sel <= 1'b1;
		flow <= 1'b0;
		awake_en <= 1'b0;
		wst(ST_SLEEP, 200);
		@(posedge clk);
		ser_v <= 1'b1;
		@(posedge clk);
		ser_v <= 1'b0;
		#1 chk(st === ST_SLEEP && sacc === 1'b0 && cts_n === 1'b0 && awake === 1'b0, "flow off asleep");
		@(posedge clk);
		spi_sel <= 1'b0;
		wst(ST_HOLD, 3);
		chk(awake === 1'b1 && sacc === 1'b1 && cts_n === 1'b0, "pin wake");
		@(posedge clk);
		spi_sel <= 1'b1;
		cyc(3);
		@(posedge clk);
		ser_v <= 1'b1;
		@(posedge clk);
		ser_v <= 1'b0;
		cyc(4);
		chk(st === ST_HOLD, "serial activity kept awake");
		wst(ST_SLEEP, 40);
		final_report();
	end
endmodule
`default_nettype wire
